// file: pkg/dpr_map.vh
// Constants and register map of the day performance register pair
`ifndef DPR_MAP_VH
`define DPR_MAP_VH
`define DPR_ADDR_CTRL 8'h00
`define DPR_ADDR_STATUS 8'h04
`define DPR_ADDR_CUR_COUNT 8'h08
`define DPR_ADDR_CUR_SECS 8'h0c
`define DPR_ADDR_REC_COUNT 8'h10
`define DPR_ADDR_REC_SECS 8'h14
`define DPR_ADDR_REC_STAMP 8'h18
`define DPR_ADDR_NOW_STAMP 8'h1c
`define DPR_CTRL_ENABLE 0
`define DPR_CTRL_LOSS 1
`define DPR_CTRL_PRESET 2
`define DPR_CTRL_OUTSIDE 3
`define DPR_STAT_CUR_DOUBT 0
`define DPR_STAT_REC_DOUBT 1
`define DPR_STAT_ENABLE 2
`define DPR_NOMINAL_SECS 17'd86400
`define DPR_TOLERANCE_SECS 17'd10
`define DPR_SECS_MAX 17'h1ffff
`define DPR_REC_DOUBT_INIT 1'b1
`define DPR_STAMP_INIT 32'h0000_0000
`define DPR_RESP_OKAY 2'b00
`define DPR_RESP_SLVERR 2'b10
`endif

// file: hdl/dpr_sync.v
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps
module dpr_sync #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // dpr_sync

// file: hdl/dpr_edge.v
// Rising-edge detector producing one-cycle pulses
`timescale 1ns/1ps
module dpr_edge #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] level_in,
    output reg [WIDTH-1:0] rise_pulse
);
    reg [WIDTH-1:0] last;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            last <= {WIDTH{1'b0}};
            rise_pulse <= {WIDTH{1'b0}};
        end else begin
            last <= level_in;
            rise_pulse <= level_in & ~last;
        end
    end
endmodule // dpr_edge

// file: hdl/dpr_top.v
// Current and recent 24-hour performance register pair with AXI4-Lite access
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dpr_map.vh"
module dpr_top (
    input wire core_clk,
    input wire rst_b,
    input wire monitor_second_tick,
    input wire day_period_tick,
    input wire time_preset,
    input wire preset_outside,
    input wire data_loss,
    input wire event_second,
    input wire [31:0] element_time_of_day,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] recent_day_count,
    output reg data_doubt_indicator,
    output reg [16:0] seconds_processed
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and event pulses

    wire [5:0] pins_sync;
    wire [37:0] stamp_sync_bus;
    wire [5:0] pin_rise;
    wire sec_pulse;
    wire day_pulse;
    wire preset_pulse;
    wire outside_pulse;
    wire loss_pulse;
    wire evt_pulse;

    dpr_sync #(.WIDTH(38)) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in({element_time_of_day, event_second, data_loss, preset_outside,
                   time_preset, day_period_tick, monitor_second_tick}),
        .sync_out(stamp_sync_bus)
    );

    assign pins_sync = stamp_sync_bus[5:0];

    dpr_edge #(.WIDTH(6)) u_edge (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .level_in(pins_sync),
        .rise_pulse(pin_rise)
    );

    assign sec_pulse = pin_rise[0];
    assign day_pulse = pin_rise[1];
    assign preset_pulse = pin_rise[2];
    assign outside_pulse = pin_rise[3];
    assign loss_pulse = pin_rise[4];
    assign evt_pulse = pin_rise[5];

    ////////////////////////////////////////////////////////////////////////////////
    // Time-of-day capture

    // Word crosses bit by bit; only a value seen twice in a row is trusted
    reg [31:0] stamp_prev;
    reg [31:0] stamp_stable;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stamp_prev <= `DPR_STAMP_INIT;
            stamp_stable <= `DPR_STAMP_INIT;
        end else begin
            stamp_prev <= stamp_sync_bus[37:6];
            if (stamp_prev == stamp_sync_bus[37:6])
                stamp_stable <= stamp_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function [16:0] sat_inc;
        input [16:0] value;
        begin
            if (value == `DPR_SECS_MAX)
                sat_inc = value;
            else
                sat_inc = value + 17'd1;
        end
    endfunction

    function [31:0] cnt_inc;
        input [31:0] value;
        begin
            if (value == 32'hffff_ffff)
                cnt_inc = value;
            else
                cnt_inc = value + 32'h0000_0001;
        end
    endfunction

    // Deviation check against the nominal day length
    function off_nominal;
        input [16:0] secs;
        begin
            off_nominal = (secs > (`DPR_NOMINAL_SECS + `DPR_TOLERANCE_SECS)) ||
                          (secs < (`DPR_NOMINAL_SECS - `DPR_TOLERANCE_SECS));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Control register

    reg [0:0] ctrl;
    reg enable_d;
    wire processing;
    wire start_proc;
    wire sw_loss;
    wire sw_preset;
    wire sw_outside;

    assign processing = ctrl[`DPR_CTRL_ENABLE];
    assign start_proc = processing & ~enable_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Current register

    reg [31:0] cur_count;
    reg [16:0] cur_secs;
    reg cur_doubt;
    reg [31:0] rec_stamp;
    wire end_period;
    wire preset_any;
    wire outside_any;
    wire loss_any;

    assign preset_any = preset_pulse | sw_preset;
    assign outside_any = outside_pulse | sw_outside;
    assign loss_any = loss_pulse | sw_loss;
    // Period ends on the day tick or a clock jump outside the interval
    assign end_period = processing & (day_pulse | (preset_any & outside_any));

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_count <= 32'h0000_0000;
            cur_secs <= 17'h00000;
            cur_doubt <= 1'b0;
            enable_d <= 1'b0;
        end else begin
            enable_d <= processing;
            if (start_proc) begin
                cur_count <= 32'h0000_0000;
                cur_secs <= 17'h00000;
                cur_doubt <= 1'b0;
            end else if (end_period) begin
                // Fresh period after transfer
                cur_count <= 32'h0000_0000;
                cur_secs <= 17'h00000;
                // Loss in the closing cycle belongs to the new day: set wins
                cur_doubt <= loss_any;
            end else if (processing) begin
                if (sec_pulse)
                    cur_secs <= sat_inc(cur_secs);
                if (evt_pulse)
                    cur_count <= cnt_inc(cur_count);
                // Large clock preset inside the interval still marks the day
                if (loss_any || preset_any)
                    cur_doubt <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Recent register

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            recent_day_count <= 32'h0000_0000;
            seconds_processed <= 17'h00000;
            data_doubt_indicator <= `DPR_REC_DOUBT_INIT;
            rec_stamp <= `DPR_STAMP_INIT;
        end else if (start_proc) begin
            recent_day_count <= 32'h0000_0000;
            seconds_processed <= 17'h00000;
            data_doubt_indicator <= `DPR_REC_DOUBT_INIT;
            rec_stamp <= `DPR_STAMP_INIT;
        end else if (end_period) begin
            // Old contents overwritten in one step; elapsed check on final count
            recent_day_count <= cur_count;
            seconds_processed <= cur_secs;
            data_doubt_indicator <= cur_doubt | off_nominal(cur_secs);
            // Stamp taken only at transfer, so a later preset inside the interval cannot touch it
            rec_stamp <= stamp_stable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    reg [7:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    reg have_aw;
    reg have_w;
    reg [2:0] pulse_bits;
    wire wr_fire;

    assign wr_fire = have_aw & have_w & ~s_axi_bvalid;
    assign sw_loss = pulse_bits[0];
    assign sw_preset = pulse_bits[1];
    assign sw_outside = pulse_bits[2];

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DPR_RESP_OKAY;
            have_aw <= 1'b0;
            have_w <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            ctrl <= 1'b0;
            pulse_bits <= 3'b000;
        end else begin
            pulse_bits <= 3'b000;
            s_axi_awready <= ~have_aw & ~s_axi_awready;
            s_axi_wready <= ~have_w & ~s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw <= 1'b1;
                wr_addr <= s_axi_awaddr[7:0];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                have_aw <= 1'b0;
                have_w <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_addr == `DPR_ADDR_CTRL) begin
                    s_axi_bresp <= `DPR_RESP_OKAY;
                    if (wr_strb[0]) begin
                        ctrl[`DPR_CTRL_ENABLE] <= wr_data[`DPR_CTRL_ENABLE];
                        pulse_bits <= {wr_data[`DPR_CTRL_OUTSIDE], wr_data[`DPR_CTRL_PRESET],
                                       wr_data[`DPR_CTRL_LOSS]};
                    end
                end else if (wr_addr[7:5] == 3'b000 && wr_addr[1:0] == 2'b00) begin
                    s_axi_bresp <= `DPR_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `DPR_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DPR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & ~s_axi_arvalid ? 1'b1 :
                             (~s_axi_rvalid & ~s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `DPR_RESP_OKAY;
                case (s_axi_araddr[7:0])
                    `DPR_ADDR_CTRL: s_axi_rdata <= {28'h0000000, 3'b000, ctrl[`DPR_CTRL_ENABLE]};
                    `DPR_ADDR_STATUS: s_axi_rdata <= {29'h00000000, processing,
                                                      data_doubt_indicator, cur_doubt};
                    `DPR_ADDR_CUR_COUNT: s_axi_rdata <= cur_count;
                    `DPR_ADDR_CUR_SECS: s_axi_rdata <= {15'h0000, cur_secs};
                    `DPR_ADDR_REC_COUNT: s_axi_rdata <= recent_day_count;
                    `DPR_ADDR_REC_SECS: s_axi_rdata <= {15'h0000, seconds_processed};
                    `DPR_ADDR_REC_STAMP: s_axi_rdata <= rec_stamp;
                    `DPR_ADDR_NOW_STAMP: s_axi_rdata <= stamp_stable;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `DPR_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b0;
            end
        end
    end
endmodule // dpr_top

// file: test/dpr_top_sva.sv
// Port checker for the day performance register pair
`timescale 1ns/1ps
`include "dpr_map.vh"
module dpr_top_sva (
    input wire core_clk,
    input wire rst_b,
    input wire day_period_tick,
    input wire preset_outside,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] recent_day_count,
    input wire data_doubt_indicator,
    input wire [16:0] seconds_processed
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (!rst_b);
////////////////////////////////
// Only a period end, a preset or a bus write may move the recent register
reg [3:0] since_trig;
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        since_trig <= 4'hf;
    end else if (day_period_tick || preset_outside || (s_axi_wvalid && s_axi_wready)) begin
        since_trig <= 4'h0;
    end else if (since_trig != 4'hf) begin
        since_trig <= since_trig + 4'h1;
    end
end
sequence s_aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence s_recent_moves;
    $changed(recent_day_count) || $changed(seconds_processed) || $changed(data_doubt_indicator);
endsequence
////////////////////////////////
property p_recent_init;
    $rose(rst_b) |-> data_doubt_indicator && seconds_processed == 17'h0 && recent_day_count == 32'h0;
endproperty
a_recent_init: assert property (p_recent_init) else $error("recent register bad after reset");
property p_recent_cause;
    s_recent_moves |-> since_trig < 4'h8;
endproperty
a_recent_cause: assert property (p_recent_cause) else $error("recent register moved alone");
property p_day_doubt;
    $changed(seconds_processed) && (seconds_processed < 17'h15176 || seconds_processed > 17'h1518a)
        |-> data_doubt_indicator;
endproperty
a_day_doubt: assert property (p_day_doubt) else $error("off-length day not in doubt");
property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
endproperty
a_read_answer: assert property (p_read_answer) else $error("read answer late");
property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_read_hold: assert property (p_read_hold) else $error("read data dropped early");
property p_read_refused;
    s_axi_rvalid && s_axi_rresp == `DPR_RESP_SLVERR |-> s_axi_rdata == 32'h0;
endproperty
a_read_refused: assert property (p_read_refused) else $error("refused read carries data");
property p_read_busy;
    s_axi_rvalid |-> !s_axi_arready;
endproperty
a_read_busy: assert property (p_read_busy) else $error("new read taken during answer");
property p_write_answer;
    s_aw_w_taken |-> ##[1:3] s_axi_bvalid;
endproperty
a_write_answer: assert property (p_write_answer) else $error("write answer missing");
property p_write_single;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
endproperty
a_write_single: assert property (p_write_single) else $error("write answer repeated");
endmodule // dpr_top_sva

// file: test/dpr_feed_model.sv
// Upstream monitoring pins and time-of-day source
`timescale 1ns/1ps
module dpr_feed_model (
    input wire core_clk,
    output wire monitor_second_tick,
    output wire time_preset,
    output wire preset_outside,
    output wire data_loss,
    output wire event_second,
    output wire day_period_tick,
    output reg [31:0] element_time_of_day
);
reg [5:0] pins;
assign {day_period_tick, event_second, data_loss, preset_outside, time_preset,
    monitor_second_tick} = pins;
initial begin
    pins = 6'h00;
    element_time_of_day = 32'h0;
end
////////////////////////////////
// Held 3 cycles so the two-flop synchroniser cannot miss a pulse
task pulse(input [5:0] mask, input integer n);
    repeat (n) begin
        @(posedge core_clk);
        pins <= mask;
        repeat (3) @(posedge core_clk);
        pins <= 6'h00;
        repeat (3) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
endtask
task set_time(input [31:0] t);
    @(posedge core_clk);
    element_time_of_day <= t;
endtask
endmodule // dpr_feed_model

// file: test/tb.sv
// Testbench for the day performance register pair
`timescale 1ns/1ps
`include "dpr_map.vh"
module tb;
reg core_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
reg [31:0] awaddr, wdata, araddr;
wire sec_t, pre_t, out_t, loss_t, ev_t, day_t, awready, wready, bvalid, arready, rvalid;
wire rec_doubt;
wire [1:0] bresp, rresp;
wire [31:0] tod, rdata, rec_count;
wire [16:0] rec_secs;
integer miscompares, checked;
dpr_feed_model u_feed (.core_clk(core_clk), .monitor_second_tick(sec_t), .time_preset(pre_t),
    .preset_outside(out_t), .data_loss(loss_t), .event_second(ev_t), .day_period_tick(day_t),
    .element_time_of_day(tod));
dpr_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .monitor_second_tick(sec_t),
    .day_period_tick(day_t), .time_preset(pre_t), .preset_outside(out_t), .data_loss(loss_t),
    .event_second(ev_t), .element_time_of_day(tod), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .recent_day_count(rec_count), .data_doubt_indicator(rec_doubt),
    .seconds_processed(rec_secs));
always #25 core_clk = ~core_clk;
////////////////////////////////
task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
endtask
task complete_run;
    $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask
// Bounded wait; a hang is counted and ends the run
task tick(inout integer n);
    @(posedge core_clk);
    n = n + 1;
    if (n > 100) begin
        miscompares = miscompares + 1;
        complete_run;
    end
endtask
task wr(input [31:0] a, input [31:0] d, input [1:0] exp_resp);
    integer n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
        tick(n);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk({30'h0, bresp}, {30'h0, exp_resp});
    bready <= 1'b0;
    @(posedge core_clk);
endtask
// Data taken at the edge where rvalid is seen with rready already high
task rchk(input [31:0] a, input [31:0] exp, input [1:0] exp_resp);
    integer n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
        tick(n);
        if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, exp_resp});
    rready <= 1'b0;
    @(posedge core_clk);
endtask
////////////////////////////////
initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    miscompares = 0;
    checked = 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk({15'h0, rec_secs}, 32'h0);
    chk(rec_count, 32'h0);
    chk({31'h0, rec_doubt}, 32'h1);
    rchk(`DPR_ADDR_REC_STAMP, 32'h0, 2'h0);
    wr(`DPR_ADDR_CTRL, 32'h1, `DPR_RESP_OKAY);
    rchk(`DPR_ADDR_STATUS, 32'h6, 2'h0);
    rchk(`DPR_ADDR_CUR_SECS, 32'h0, 2'h0);
    $display("test start-up done");
    u_feed.set_time(32'h0102_0304);
    u_feed.pulse(6'h11, 3);
    u_feed.pulse(6'h01, 2);
    rchk(`DPR_ADDR_CUR_SECS, 32'h5, 2'h0);
    rchk(`DPR_ADDR_CUR_COUNT, 32'h3, 2'h0);
    u_feed.pulse(6'h20, 1);
    chk({15'h0, rec_secs}, 32'h5);
    chk(rec_count, 32'h3);
    chk({31'h0, rec_doubt}, 32'h1);
    rchk(`DPR_ADDR_REC_STAMP, 32'h0102_0304, 2'h0);
    rchk(`DPR_ADDR_CUR_SECS, 32'h0, 2'h0);
    rchk(`DPR_ADDR_CUR_COUNT, 32'h0, 2'h0);
    rchk(`DPR_ADDR_STATUS, 32'h6, 2'h0);
    $display("test period end done");
    u_feed.pulse(6'h08, 1);
    rchk(`DPR_ADDR_STATUS, 32'h7, 2'h0);
    u_feed.pulse(6'h01, 2);
    u_feed.set_time(32'h0a0b_0c0d);
    u_feed.pulse(6'h02, 1);
    rchk(`DPR_ADDR_REC_STAMP, 32'h0102_0304, 2'h0);
    chk({15'h0, rec_secs}, 32'h5);
    u_feed.pulse(6'h06, 1);
    chk({15'h0, rec_secs}, 32'h2);
    chk(rec_count, 32'h0);
    wr(`DPR_ADDR_CTRL, 32'h3, `DPR_RESP_OKAY);
    rchk(`DPR_ADDR_STATUS, 32'h7, 2'h0);
    wr(`DPR_ADDR_CTRL, 32'hd, `DPR_RESP_OKAY);
    chk({15'h0, rec_secs}, 32'h0);
    rchk(`DPR_ADDR_NOW_STAMP, 32'h0a0b_0c0d, 2'h0);
    rchk(`DPR_ADDR_CTRL, 32'h1, 2'h0);
    $display("test presets done");
    wr(`DPR_ADDR_REC_COUNT, 32'hffff, `DPR_RESP_OKAY);
    wr(32'h0e, 32'h0, `DPR_RESP_SLVERR);
    rchk(`DPR_ADDR_REC_COUNT, 32'h0, 2'h0);
    rchk(32'h20, 32'h0, `DPR_RESP_SLVERR);
    $display("test bus refusals done");
    complete_run;
end
endmodule // tb
bind dpr_top dpr_top_sva u_sva (.core_clk(core_clk), .rst_b(rst_b),
    .day_period_tick(day_period_tick), .preset_outside(preset_outside),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .recent_day_count(recent_day_count), .data_doubt_indicator(data_doubt_indicator),
    .seconds_processed(seconds_processed));
